// ### design/cacr_regs.sv
// codec audio control register bank behind the serial control port
// assumes coding mode, substitution enables and pcm frame data come from
// neighbouring logic on clk; the serial pins come from the host asynchronously
`default_nettype none

module cacr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial control port pins
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  // coding mode and substitution enables
  input wire logic coding_companded,
  input wire logic rx_substitute_on,
  input wire logic tx_substitute_on,
  // pcm frame side
  input wire logic frame_strobe,
  input wire logic [7:0] pcm_rx_input,
  input wire logic [7:0] encoder_byte,
  output logic [7:0] decoder_byte,
  output logic [7:0] pcm_tx_output,
  // decoded controls
  output logic power_down,
  output var cacr_pkg::cacr_ctrl_type ctrl
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [cacr_pkg::SYNC_N-1:0] pin_meta;
  logic [cacr_pkg::SYNC_N-1:0] pin_sync;
  wire [cacr_pkg::SYNC_N-1:0] pin_raw = {ser_clk, ser_cs_n, ser_din};

  genvar gi;
  generate
    for (gi = 0; gi < cacr_pkg::SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_meta[gi] <= cacr_pkg::SYNC_RST[gi];
          pin_sync[gi] <= cacr_pkg::SYNC_RST[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  cacr_pkg::cacr_cmd_type cmd;
  logic [7:0] rd_data;

  cacr_serial u_serial (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclk_s(pin_sync[2]),
    .csn_s(pin_sync[1]),
    .sdi_s(pin_sync[0]),
    .rd_data(rd_data),
    .cmd(cmd),
    .sdo(ser_dout),
    .sdo_oe(ser_dout_oe)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [7:0] addr, input logic [3:0] idx);
    return addr[cacr_pkg::ADDR_IDX_MSB:cacr_pkg::ADDR_IDX_LSB] == idx;
  endfunction

  wire wr_rx_data = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_RX_DATA);
  wire wr_tx_data = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_TX_DATA);
  wire wr_routing = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_ROUTING);
  wire wr_gain = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_GAIN);
  wire wr_atten = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_ATTEN);
  wire wr_tone = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_TONE);
  wire wr_first_div = cmd.wr_done & hits(cmd.addr, cacr_pkg::IDX_FIRST_DIV);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] receive_path_data;
  logic [7:0] transmit_substitute_data;
  logic [7:0] audio_routing;
  logic [7:0] transmit_sidetone_gain;
  logic [7:0] output_attenuation;
  logic [7:0] tone_control;
  logic [7:0] first_tone_divisor;
  logic [7:0] rx_capture;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      receive_path_data <= cacr_pkg::RST_RX_DATA; // R10
      transmit_substitute_data <= cacr_pkg::RST_TX_DATA;
      audio_routing <= cacr_pkg::RST_ROUTING;
      transmit_sidetone_gain <= cacr_pkg::RST_GAIN;
      output_attenuation <= cacr_pkg::RST_ATTEN;
      tone_control <= cacr_pkg::RST_TONE;
      first_tone_divisor <= cacr_pkg::RST_FIRST_DIV;
    end else begin
      if (wr_rx_data) receive_path_data <= cmd.data; // R1
      if (wr_tx_data) transmit_substitute_data <= cmd.data; // R2
      if (wr_routing) audio_routing <= cmd.data;
      if (wr_gain) transmit_sidetone_gain <= cmd.data;
      if (wr_atten) output_attenuation <= cmd.data;
      if (wr_tone) tone_control <= cmd.data; // R19
      if (wr_first_div) first_tone_divisor <= cmd.data; // R18
    end
  end

  // ----------------------------------------------------------------
  // read-back mux
  // ----------------------------------------------------------------
  // the transmit substitute byte is write only and reads as zero
  assign rd_data = hits(cmd.addr, cacr_pkg::IDX_RX_DATA) ? rx_capture : // R1
                   hits(cmd.addr, cacr_pkg::IDX_ROUTING) ? audio_routing :
                   hits(cmd.addr, cacr_pkg::IDX_GAIN) ? transmit_sidetone_gain :
                   hits(cmd.addr, cacr_pkg::IDX_ATTEN) ? output_attenuation :
                   hits(cmd.addr, cacr_pkg::IDX_TONE) ? tone_control :
                   hits(cmd.addr, cacr_pkg::IDX_FIRST_DIV) ? first_tone_divisor :
                   8'h00; // R23

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  cacr_pkg::cacr_ctrl_type next_ctrl;
  wire [1:0] rx_out_code = {audio_routing[cacr_pkg::ROUTE_RXOUT_HI],
                            audio_routing[cacr_pkg::ROUTE_RXOUT_LO]};
  wire [3:0] tone_code = tone_control[cacr_pkg::HI_MSB:cacr_pkg::HI_LSB];

  assign next_ctrl.tx_input_sel_hi = audio_routing[cacr_pkg::ROUTE_TXSEL_HI]; // R4
  assign next_ctrl.tx_input_sel_lo = audio_routing[cacr_pkg::ROUTE_TXSEL_LO]; // R4
  assign next_ctrl.sidetone_on = audio_routing[cacr_pkg::ROUTE_SIDETONE]; // R5
  // the forbidden code mutes so both outputs are never driven together
  assign next_ctrl.earpiece_output = rx_out_code == cacr_pkg::RXOUT_EAR; // R6
  assign next_ctrl.loudspeaker_output = rx_out_code == cacr_pkg::RXOUT_SPK; // R6
  assign next_ctrl.tone_to_output_on = audio_routing[cacr_pkg::ROUTE_TONE]; // R7
  assign next_ctrl.rx_highpass_bypass = audio_routing[cacr_pkg::ROUTE_HPB]; // R8
  assign next_ctrl.rx_signal_to_output_on = audio_routing[cacr_pkg::ROUTE_RXSIG]; // R9
  assign next_ctrl.tx_gain = transmit_sidetone_gain[cacr_pkg::HI_MSB:cacr_pkg::HI_LSB]; // R11
  assign next_ctrl.sidetone_gain = transmit_sidetone_gain[cacr_pkg::LO_MSB:cacr_pkg::LO_LSB]; // R12
  assign next_ctrl.earpiece_gain = output_attenuation[cacr_pkg::HI_MSB:cacr_pkg::HI_LSB]; // R13
  assign next_ctrl.extra_out_gain = output_attenuation[cacr_pkg::LO_MSB:cacr_pkg::LO_LSB]; // R13
  // from -24 dB down the middle two code bits are don't-care, forced to zero
  assign next_ctrl.tone_atten = tone_code[3] ?
                                {tone_code[3], cacr_pkg::TONE_DC_ZERO, tone_code[0]} :
                                tone_code; // R14
  assign next_ctrl.first_tone_select = tone_control[cacr_pkg::TONE_F1]; // R15
  assign next_ctrl.second_tone_select = tone_control[cacr_pkg::TONE_F2]; // R15
  assign next_ctrl.sine_select = tone_control[cacr_pkg::TONE_SINE]; // R16
  assign next_ctrl.tone_into_transmit = tone_control[cacr_pkg::TONE_DE]; // R17
  assign next_ctrl.first_tone_divisor = first_tone_divisor; // R18

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= cacr_pkg::CTRL_RST; // R10
      power_down <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      if (cmd.addr_done) power_down <= cmd.addr[cacr_pkg::ADDR_PWR_BIT]; // R20
    end
  end

  // ----------------------------------------------------------------
  // pcm frame substitution
  // ----------------------------------------------------------------
  wire rx_use_reg = coding_companded & rx_substitute_on; // R3
  wire tx_use_reg = coding_companded & tx_substitute_on; // R3

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      decoder_byte <= 8'h00;
      pcm_tx_output <= 8'h00;
      rx_capture <= 8'h00;
    end else if (frame_strobe) begin
      decoder_byte <= rx_use_reg ? receive_path_data : pcm_rx_input; // R22
      pcm_tx_output <= tx_use_reg ? transmit_substitute_data : encoder_byte; // R23
      if (!rx_use_reg) rx_capture <= pcm_rx_input; // R22
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_written(logic [3:0] idx);
    cmd.wr_done && hits(cmd.addr, idx);
  endsequence

  sequence s_settled;
    ##2 1'b1;
  endsequence

  tx_input_sel_a: assert property (s_written(cacr_pkg::IDX_ROUTING) |-> s_settled ##0
      {ctrl.tx_input_sel_hi, ctrl.tx_input_sel_lo} == $past(cmd.data[7:6], 2)) // R4
    else $error("transmit input select not taken from routing write");

  sidetone_on_a: assert property (s_written(cacr_pkg::IDX_ROUTING) |-> s_settled ##0
      ctrl.sidetone_on == $past(cmd.data[5], 2)) // R5
    else $error("sidetone enable wrong after routing write");

  rx_out_excl_a: assert property (!(ctrl.earpiece_output && ctrl.loudspeaker_output) &&
      (ctrl.earpiece_output == ($past(rx_out_code) == 2'h1))) // R6
    else $error("receive output select decoded wrongly");

  tone_route_a: assert property (s_written(cacr_pkg::IDX_ROUTING) |-> s_settled ##0
      ctrl.tone_to_output_on == $past(cmd.data[2], 2)) // R7
    else $error("tone route enable wrong after routing write");

  hpf_bypass_a: assert property (s_written(cacr_pkg::IDX_ROUTING) |-> s_settled ##0
      ctrl.rx_highpass_bypass == $past(cmd.data[1], 2)) // R8
    else $error("high-pass bypass wrong after routing write");

  rx_signal_a: assert property (s_written(cacr_pkg::IDX_ROUTING) |-> s_settled ##0
      ctrl.rx_signal_to_output_on == $past(cmd.data[0], 2)) // R9
    else $error("receive signal enable wrong after routing write");

  reset_dflt_a: assert property ($fell(sys_rst) |->
      ctrl == cacr_pkg::CTRL_RST && !power_down && audio_routing == 8'h00) // R10
    else $error("defaults not loaded by reset");

  gain_nibble_a: assert property (s_written(cacr_pkg::IDX_GAIN) |-> s_settled ##0
      ctrl.tx_gain == $past(cmd.data[7:4], 2) &&
      ctrl.sidetone_gain == $past(cmd.data[3:0], 2)) // R11 R12
    else $error("gain nibbles not split correctly");

  out_atten_a: assert property (s_written(cacr_pkg::IDX_ATTEN) |-> s_settled ##0
      ctrl.earpiece_gain == $past(cmd.data[7:4], 2) &&
      ctrl.extra_out_gain == $past(cmd.data[3:0], 2)) // R13
    else $error("attenuation nibbles not split correctly");

  tone_atten_a: assert property (ctrl.tone_atten[3] |-> // R14
      ctrl.tone_atten[2:1] == 2'h0 && ctrl.tone_atten[0] == $past(tone_control[4]))
    else $error("tone attenuation ignored bits not cleared");

  tone_bits_a: assert property (s_written(cacr_pkg::IDX_TONE) |-> s_settled ##0
      {ctrl.first_tone_select, ctrl.second_tone_select, ctrl.sine_select,
       ctrl.tone_into_transmit} == $past(cmd.data[3:0], 2)) // R15 R16 R17
    else $error("tone control bits wrong after write");

  divisor_a: assert property (s_written(cacr_pkg::IDX_FIRST_DIV) |-> s_settled ##0
      ctrl.first_tone_divisor == $past(cmd.data, 2)) // R18
    else $error("first tone divisor not stored");

  rx_store_a: assert property (s_written(cacr_pkg::IDX_RX_DATA) |=>
      receive_path_data == $past(cmd.data)) // R1
    else $error("receive data byte not stored");

  power_bit_a: assert property (cmd.addr_done |=> power_down == $past(cmd.addr[7])) // R20
    else $error("power down bit not taken from address byte");

  tx_subst_a: assert property (frame_strobe && tx_use_reg |=>
      pcm_tx_output == $past(transmit_substitute_data)) // R2 R23
    else $error("transmit substitution byte not sent");

  linear_pass_a: assert property (frame_strobe && !coding_companded |=>
      pcm_tx_output == $past(encoder_byte) && decoder_byte == $past(pcm_rx_input)) // R3
    else $error("data bytes acted in linear coding");

  rx_subst_a: assert property (frame_strobe && rx_use_reg |=>
      decoder_byte == $past(receive_path_data) && $stable(rx_capture)) // R22
    else $error("receive substitution not applied");

endmodule

`default_nettype wire

// ### design/cacr_pkg.sv
// constants, types and field layout of the codec audio control register bank
// assumes the serial control shifter and the register bank share one clock
//
// Overview of operation
// [R1] receive data byte is written by host; reads give the last received byte
// [R2] transmit data byte replaces encoder output when transmit substitution is on
// [R3] both data bytes act only in companded coding; linear coding ignores them
// [R4] routing bits 7:6 pick transmit input: mute, mic one, two or three
// [R5] routing bit 5 turns the sidetone path on when set
// [R6] routing bits 4:3 pick mute, earpiece or loudspeaker; code 11 forbidden
// [R7] routing bit 2 lets ring or tone reach the selected output
// [R8] routing bit 1 set bypasses the receive high-pass filter
// [R9] routing bit 0 lets decoded receive signal reach the selected output
// [R10] power-on loads every marked default value into every field
// [R11] gain upper nibble is transmit gain, 1.5 dB per step from 0 dB
// [R12] gain lower nibble is sidetone gain, -12.5 dB falling 1 dB per step
// [R13] attenuation nibbles set earpiece and extra gain, 2 dB steps down
// [R14] tone bits 7:4 give 3 dB attenuation steps; bits 6:5 ignored if bit 7 set
// [R15] tone bits 3:2 pick muted, second, first or summed tones
// [R16] tone bit 1 picks sine when set, square when clear
// [R17] tone bit 0 set feeds tone generator into transmit path
// [R18] first divisor register holds unsigned byte setting first tone frequency
// [R19] host writes zero to reserved tone control bits
// [R20] address byte: bit 7 power down, bit 2 read, bit 1 data follows
// [R21] address and data bytes travel most significant bit first
// [R22] receive substitution decodes the stored byte each frame, ignoring input
// [R23] transmit substitution sends stored byte each frame; register is write only
`default_nettype none

package cacr_pkg;

  localparam int BYTE_W = 8;
  localparam int IDX_W = 4;
  localparam int SYNC_N = 3;

  // register indices carried in address byte bits 6:3
  localparam logic [3:0] IDX_RX_DATA = 4'h2;
  localparam logic [3:0] IDX_TX_DATA = 4'h3;
  localparam logic [3:0] IDX_ROUTING = 4'h4;
  localparam logic [3:0] IDX_GAIN = 4'h5;
  localparam logic [3:0] IDX_ATTEN = 4'h6;
  localparam logic [3:0] IDX_TONE = 4'h7;
  localparam logic [3:0] IDX_FIRST_DIV = 4'h8;

  // address byte layout
  localparam int ADDR_PWR_BIT = 7;
  localparam int ADDR_IDX_MSB = 6;
  localparam int ADDR_IDX_LSB = 3;
  localparam int ADDR_READ_BIT = 2;
  localparam int ADDR_DATA_BIT = 1;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // routing register fields
  localparam int ROUTE_TXSEL_HI = 7;
  localparam int ROUTE_TXSEL_LO = 6;
  localparam int ROUTE_SIDETONE = 5;
  localparam int ROUTE_RXOUT_HI = 4;
  localparam int ROUTE_RXOUT_LO = 3;
  localparam int ROUTE_TONE = 2;
  localparam int ROUTE_HPB = 1;
  localparam int ROUTE_RXSIG = 0;
  localparam logic [1:0] RXOUT_EAR = 2'h1;
  localparam logic [1:0] RXOUT_SPK = 2'h2;

  // nibble fields shared by gain, attenuation and tone registers
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  localparam int TONE_F1 = 3;
  localparam int TONE_F2 = 2;
  localparam int TONE_SINE = 1;
  localparam int TONE_DE = 0;
  localparam logic [1:0] TONE_DC_ZERO = 2'h0;

  // power-on values
  localparam logic [7:0] RST_RX_DATA = 8'h00;
  localparam logic [7:0] RST_TX_DATA = 8'h00;
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_ATTEN = 8'h00;
  localparam logic [7:0] RST_TONE = 8'h00;
  localparam logic [7:0] RST_FIRST_DIV = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h2;

  typedef struct packed {
    logic tx_input_sel_hi;
    logic tx_input_sel_lo;
    logic sidetone_on;
    logic earpiece_output;
    logic loudspeaker_output;
    logic tone_to_output_on;
    logic rx_highpass_bypass;
    logic rx_signal_to_output_on;
    logic [3:0] tx_gain;
    logic [3:0] sidetone_gain;
    logic [3:0] earpiece_gain;
    logic [3:0] extra_out_gain;
    logic [3:0] tone_atten;
    logic first_tone_select;
    logic second_tone_select;
    logic sine_select;
    logic tone_into_transmit;
    logic [7:0] first_tone_divisor;
  } cacr_ctrl_type;

  localparam cacr_ctrl_type CTRL_RST = '0;

  typedef struct packed {
    logic addr_done;
    logic wr_done;
    logic [7:0] addr;
    logic [7:0] data;
  } cacr_cmd_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_SKIP = 4'h8
  } cacr_ser_state_type;

endpackage

`default_nettype wire

// ### design/cacr_serial.sv
// serial control port shifter: address byte, then optional data byte
// assumes clock, select and data inputs are already synchronised to clk
`default_nettype none

module cacr_serial (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // synchronised pin levels
  input wire logic sclk_s,
  input wire logic csn_s,
  input wire logic sdi_s,
  // read data for the addressed register
  input wire logic [7:0] rd_data,
  // decoded transfer and serial output
  output var cacr_pkg::cacr_cmd_type cmd,
  output logic sdo,
  output logic sdo_oe
);

  cacr_pkg::cacr_ser_state_type state;
  logic sclk_d;
  logic [2:0] bitcnt;
  logic [7:0] in_sr;
  logic [7:0] out_sr;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire [7:0] next_in = {in_sr[6:0], sdi_s};
  wire last_bit = bitcnt == cacr_pkg::BIT_LAST;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= cacr_pkg::ST_IDLE;
      sclk_d <= 1'b0;
      bitcnt <= 3'h0;
      in_sr <= 8'h00;
      out_sr <= 8'h00;
      cmd <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      cmd.addr_done <= 1'b0;
      cmd.wr_done <= 1'b0;
      if (csn_s) begin
        state <= cacr_pkg::ST_IDLE;
        bitcnt <= 3'h0;
        sdo_oe <= 1'b0;
      end else begin
        unique case (state)
          cacr_pkg::ST_IDLE: begin
            state <= cacr_pkg::ST_ADDR;
          end
          cacr_pkg::ST_ADDR: begin
            if (sclk_rise) begin
              in_sr <= next_in; // R21
              bitcnt <= bitcnt + 3'h1;
              if (last_bit) begin
                cmd.addr_done <= 1'b1;
                cmd.addr <= next_in;
                state <= next_in[cacr_pkg::ADDR_DATA_BIT] ? cacr_pkg::ST_DATA : cacr_pkg::ST_SKIP; // R20
              end
            end
          end
          cacr_pkg::ST_DATA: begin
            if (cmd.addr_done) begin
              out_sr <= rd_data;
              sdo_oe <= cmd.addr[cacr_pkg::ADDR_READ_BIT]; // R20
            end
            if (sclk_fall) begin
              sdo <= out_sr[7]; // R21
            end
            if (sclk_rise) begin
              in_sr <= next_in;
              out_sr <= {out_sr[6:0], 1'b0};
              bitcnt <= bitcnt + 3'h1;
              if (last_bit) begin
                cmd.wr_done <= ~cmd.addr[cacr_pkg::ADDR_READ_BIT];
                cmd.data <= next_in;
                state <= cacr_pkg::ST_SKIP;
              end
            end
          end
          cacr_pkg::ST_SKIP: begin
            if (sclk_fall) begin
              sdo_oe <= 1'b0;
            end
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### sim/cacr_host_model.sv
// host side of the serial control port: drives clock, select and data in
// assumes clk is the device system clock at 100 ns; a serial bit lasts 8 clk
`default_nettype none

module cacr_host_model (
  // pacing clock
  input wire logic clk,
  // serial control pins
  output logic ser_clk,
  output logic ser_cs_n,
  output logic ser_din,
  input wire logic ser_dout,
  input wire logic ser_dout_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  initial begin
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_din = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // address byte, then a data byte only when address bit 1 is set
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [15:0] sh;
    int nbits;
    sh = {addr, wdat};
    nbits = addr[1] ? 16 : 8;
    rdat = 8'h00;
    wait_clk(1);
    ser_cs_n = 1'b0;
    wait_clk(6);
    for (int i = 15; i >= 16 - nbits; i--) begin
      ser_din = sh[i];
      wait_clk(4);
      ser_clk = 1'b1;
      wait_clk(4);
      // read data is sampled late in the high phase, well after its launch
      if (i < 8) begin
        // a line the device does not drive reads as the inverse of its last level
        rdat[i] = ser_dout_oe ? ser_dout : ~ser_dout;
      end
      ser_clk = 1'b0;
    end
    wait_clk(4);
    ser_cs_n = 1'b1;
    // released data line must not keep showing the last bit
    ser_din = ~ser_din;
    wait_clk(8);
  endtask
endmodule

`default_nettype wire

// ### sim/test_codec_audio_control_registers.sv
// self-checking bench for the codec audio control register bank
// assumes the host model paces all serial traffic from the system clock
`default_nettype none

module test_codec_audio_control_registers;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, sys_rst, ser_clk, ser_cs_n, ser_din, ser_dout, ser_dout_oe;
  logic coding_companded, rx_substitute_on, tx_substitute_on, frame_strobe;
  logic [7:0] pcm_rx_input, encoder_byte, decoder_byte, pcm_tx_output, rd;
  logic power_down;
  cacr_pkg::cacr_ctrl_type ctrl;
  int error_cnt = 0;
  int tests_run = 0;
  logic [3:0] rw_idx [6] = '{cacr_pkg::IDX_RX_DATA, cacr_pkg::IDX_ROUTING, cacr_pkg::IDX_GAIN,
    cacr_pkg::IDX_ATTEN, cacr_pkg::IDX_TONE, cacr_pkg::IDX_FIRST_DIV};

  cacr_regs cacr_regs_inst (.clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
    .ser_cs_n(ser_cs_n), .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .coding_companded(coding_companded), .rx_substitute_on(rx_substitute_on),
    .tx_substitute_on(tx_substitute_on), .frame_strobe(frame_strobe),
    .pcm_rx_input(pcm_rx_input), .encoder_byte(encoder_byte), .decoder_byte(decoder_byte),
    .pcm_tx_output(pcm_tx_output), .power_down(power_down), .ctrl(ctrl));

  cacr_host_model cacr_host_model_inst (.clk(clk), .ser_clk(ser_clk), .ser_cs_n(ser_cs_n),
    .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    cacr_host_model_inst.xfer({1'b0, idx, 3'h2}, d, rd);
  endtask

  task automatic rdc(input string name, input logic [3:0] idx, input logic [7:0] exp);
    cacr_host_model_inst.xfer({1'b0, idx, 3'h6}, 8'h00, rd);
    cmp(name, exp, rd);
    cmp("dout_oe", 8'h00, ser_dout_oe);
  endtask

  task automatic route(input logic [7:0] v);
    wr(cacr_pkg::IDX_ROUTING, v);
    rdc("routing", cacr_pkg::IDX_ROUTING, v);
    cmp("tx_sel", v[7:6], {ctrl.tx_input_sel_hi, ctrl.tx_input_sel_lo});
    cmp("sidetone", v[5], ctrl.sidetone_on);
    cmp("rx_out", {v[4:3] == 2'h2, v[4:3] == 2'h1},
        {ctrl.loudspeaker_output, ctrl.earpiece_output});
    cmp("rx_ctl", v[2:0], {ctrl.tone_to_output_on, ctrl.rx_highpass_bypass,
        ctrl.rx_signal_to_output_on});
  endtask

  // reserved tone bits stay zero on every write
  task automatic tone(input logic [7:0] v);
    wr(cacr_pkg::IDX_TONE, v);
    rdc("tone", cacr_pkg::IDX_TONE, v);
    cmp("tone_atten", v[7:4], ctrl.tone_atten);
    cmp("tone_sel", v[3:0], {ctrl.first_tone_select, ctrl.second_tone_select,
        ctrl.sine_select, ctrl.tone_into_transmit});
  endtask

  task automatic frame(input logic [7:0] rx, input logic [7:0] enc);
    @(negedge clk);
    pcm_rx_input = rx;
    encoder_byte = enc;
    frame_strobe = 1'b1;
    @(negedge clk);
    frame_strobe = 1'b0;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    coding_companded = 1'b0;
    rx_substitute_on = 1'b0;
    tx_substitute_on = 1'b0;
    frame_strobe = 1'b0;
    pcm_rx_input = 8'h00;
    encoder_byte = 8'h00;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 5; i++) cmp("ctrl", 8'h00, ctrl[i*8 +: 8]);
    foreach (rw_idx[i]) rdc("reset", rw_idx[i], 8'h00);
    route(8'hb5);
    route(8'h4a);
    route(8'hc0);
    route(8'h00);
    wr(cacr_pkg::IDX_GAIN, 8'h3c);
    rdc("gain", cacr_pkg::IDX_GAIN, 8'h3c);
    cmp("tx_gain", 8'h03, ctrl.tx_gain);
    cmp("side_gain", 8'h0c, ctrl.sidetone_gain);
    wr(cacr_pkg::IDX_ATTEN, 8'hf1);
    rdc("atten", cacr_pkg::IDX_ATTEN, 8'hf1);
    cmp("ear_gain", 8'h0f, ctrl.earpiece_gain);
    cmp("extra_gain", 8'h01, ctrl.extra_out_gain);
    tone(8'h8e);
    tone(8'h55);
    tone(8'h38);
    tone(8'h9c);
    wr(cacr_pkg::IDX_FIRST_DIV, 8'ha7);
    cmp("divisor", 8'ha7, ctrl.first_tone_divisor);
    wr(cacr_pkg::IDX_TX_DATA, 8'h5a);
    rdc("tx_data", cacr_pkg::IDX_TX_DATA, 8'h00);
    wr(4'h9, 8'h77);
    rdc("unmapped", 4'h9, 8'h00);
    rdc("divisor_rd", cacr_pkg::IDX_FIRST_DIV, 8'ha7);
    coding_companded = 1'b1;
    tx_substitute_on = 1'b1;
    frame(8'h3e, 8'h11);
    cmp("tx_sub", 8'h5a, pcm_tx_output);
    tx_substitute_on = 1'b0;
    frame(8'h3e, 8'h12);
    cmp("tx_enc", 8'h12, pcm_tx_output);
    coding_companded = 1'b0;
    tx_substitute_on = 1'b1;
    frame(8'h3e, 8'h13);
    cmp("tx_linear", 8'h13, pcm_tx_output);
    wr(cacr_pkg::IDX_RX_DATA, 8'hc3);
    coding_companded = 1'b1;
    rx_substitute_on = 1'b1;
    frame(8'h3e, 8'h00);
    cmp("rx_sub", 8'hc3, decoder_byte);
    rx_substitute_on = 1'b0;
    frame(8'h69, 8'h00);
    cmp("rx_pass", 8'h69, decoder_byte);
    rdc("rx_capture", cacr_pkg::IDX_RX_DATA, 8'h69);
    coding_companded = 1'b0;
    rx_substitute_on = 1'b1;
    frame(8'h24, 8'h00);
    cmp("rx_linear", 8'h24, decoder_byte);
    cacr_host_model_inst.xfer({1'b1, cacr_pkg::IDX_ROUTING, 3'h0}, 8'hff, rd);
    cmp("power_down", 8'h01, power_down);
    cacr_host_model_inst.xfer({1'b0, cacr_pkg::IDX_ROUTING, 3'h0}, 8'hff, rd);
    cmp("power_up", 8'h00, power_down);
    rdc("no_data", cacr_pkg::IDX_ROUTING, 8'h00);
    stop_test();
  end
endmodule

`default_nettype wire
